// *** core/serial_flash_spi_frontend.sv ***
`timescale 1ns/1ps
`include "flash_front_params.svh"

module serial_flash_spi_frontend
    import flash_front_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic serialClk,
    input wire logic serialIn,
    input wire logic chipEnable_n,
    input wire logic pausePin_n,
    input wire logic protectPin_n,
    output logic serialOut,
    output logic serialOutEn,
    input wire logic [7:0] txByte,
    output logic txTake,
    output logic [7:0] rxByte,
    output logic rxValid,
    output logic frameStart,
    output logic frameEnd,
    input wire logic internalBusy,
    output logic standby,
    output logic active,
    output logic paused,
    input wire logic zoneWrite,
    input wire logic [`ZONE_BITS-1:0] zoneIn,
    output logic [`ZONE_BITS-1:0] zoneBits,
    output logic zoneRefused
);

    // Synchronised pins
    logic clkSync;
    logic dinSync;
    logic selSync_n;
    logic pauseSync_n;
    logic protSync_n;

    sync_two_flop syncClk
    (
        .mclk(mclk), .sys_rst(sys_rst),
        .asyncIn(serialClk), .syncOut(clkSync)
    );
    sync_two_flop syncDin
    (
        .mclk(mclk), .sys_rst(sys_rst),
        .asyncIn(serialIn), .syncOut(dinSync)
    );
    sync_two_flop #(.RESET_LEVEL(1'b1)) syncSel
    (
        .mclk(mclk), .sys_rst(sys_rst),
        .asyncIn(chipEnable_n), .syncOut(selSync_n)
    );
    sync_two_flop #(.RESET_LEVEL(1'b1)) syncPause
    (
        .mclk(mclk), .sys_rst(sys_rst),
        .asyncIn(pausePin_n), .syncOut(pauseSync_n)
    );
    sync_two_flop #(.RESET_LEVEL(1'b1)) syncProt
    (
        .mclk(mclk), .sys_rst(sys_rst),
        .asyncIn(protectPin_n), .syncOut(protSync_n)
    );

    // Whole state of the front end
    typedef struct packed
    {
        logic clkPrev;
        logic selPrev_n;
        logic armed;
        logic inFrame;
        pause_e pause;
        logic [2:0] rxCount;
        logic [6:0] rxShift;
        logic [7:0] rxData;
        logic rxStrobe;
        logic [2:0] txCount;
        logic [7:0] txShift;
        logic txLoad;
        logic outBit;
        logic outEn;
        logic startPulse;
        logic endPulse;
        power_e power;
    } state_s;

    state_s st_reg;
    state_s st_next;

    // Edges of the sampled serial clock and select, and the clock gate
    logic clkRise;
    logic clkFall;
    logic selFall;
    logic selRise;
    logic clkLive;

    assign clkRise = clkSync && !st_reg.clkPrev;
    assign clkFall = !clkSync && st_reg.clkPrev;
    assign selFall = !selSync_n && st_reg.selPrev_n;
    assign selRise = selSync_n && !st_reg.selPrev_n;
    // Pause in force, including the wait for the clock low on the way out
    function automatic logic isPaused(input pause_e p);
        return (p == PAUSE_ON) || (p == PAUSE_LEAVING);
    endfunction

    // Clock is heeded only in frame and outside the pause condition
    assign clkLive = st_reg.inFrame && !isPaused(st_reg.pause);

    // Next state
    always_comb
    begin
        st_next = st_reg;
        st_next.clkPrev = clkSync;
        st_next.selPrev_n = selSync_n;
        st_next.rxStrobe = 1'b0;
        st_next.txLoad = 1'b0;
        st_next.startPulse = 1'b0;
        st_next.endPulse = 1'b0;

        // Power state follows select and internal cycles
        if (!selSync_n)
        begin
            st_next.power = PWR_ACTIVE;
        end
        else if (internalBusy)
        begin
            st_next.power = PWR_BUSY_DESEL;
        end
        else
        begin
            st_next.power = PWR_STANDBY;
        end

        // Pause tracking, entry and exit only while clock is low
        unique case (st_reg.pause)
            PAUSE_IDLE:
            begin
                // Pause needs the device selected
                if (!pauseSync_n && st_reg.inFrame)
                begin
                    st_next.pause = PAUSE_ARMED;
                end
            end
            PAUSE_ARMED:
            begin
                if (pauseSync_n)
                begin
                    st_next.pause = PAUSE_IDLE;
                end
                else if (!clkSync)
                begin
                    st_next.pause = PAUSE_ON;
                end
            end
            PAUSE_ON:
            begin
                if (pauseSync_n)
                begin
                    st_next.pause = PAUSE_LEAVING;
                end
            end
            PAUSE_LEAVING:
            begin
                if (!pauseSync_n)
                begin
                    st_next.pause = PAUSE_ON;
                end
                else if (!clkSync)
                begin
                    st_next.pause = PAUSE_IDLE;
                end
            end
        endcase

        // Frame control
        if (selFall && pauseSync_n)
        begin
            // First select fall after reset arms decoding
            st_next.armed = 1'b1;
            st_next.inFrame = 1'b1;
            st_next.startPulse = 1'b1;
            st_next.rxCount = 3'h0;
            st_next.txCount = 3'h0;
            st_next.txShift = txByte;
            st_next.txLoad = 1'b1;
        end
        else if (selRise)
        begin
            // Deselect ends the frame; under pause it resets the interface
            st_next.inFrame = 1'b0;
            st_next.pause = PAUSE_IDLE;
            st_next.endPulse = st_reg.inFrame;
            st_next.rxCount = 3'h0;
            st_next.txCount = 3'h0;
        end
        else if (clkLive && st_reg.armed)
        begin
            if (clkRise && (st_reg.pause != PAUSE_LEAVING))
            begin
                // Sample input, MSB first
                st_next.rxShift = {st_reg.rxShift[5:0], dinSync};
                st_next.rxCount = st_reg.rxCount + 3'h1;
                if (st_reg.rxCount == `BYTE_LAST)
                begin
                    st_next.rxData = {st_reg.rxShift, dinSync};
                    st_next.rxStrobe = 1'b1;
                end
            end
            // A fall with no rise before it in the frame (mode 3 lead-in) shifts nothing
            if (clkFall && (st_reg.txCount != st_reg.rxCount))
            begin
                // Shift next output bit after falling edge
                st_next.txCount = st_reg.txCount + 3'h1;
                if (st_reg.txCount == `BYTE_LAST)
                begin
                    st_next.txShift = txByte;
                    st_next.txLoad = 1'b1;
                end
                else
                begin
                    st_next.txShift = {st_reg.txShift[6:0], 1'b0};
                end
            end
        end

        // Output drives only selected and not paused
        st_next.outEn = st_next.inFrame && !isPaused(st_next.pause)
            && !selSync_n;
        st_next.outBit = st_next.txShift[7];
    end

    // State register
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_reg <= '{clkPrev: 1'b0, selPrev_n: 1'b1, armed: 1'b0, inFrame: 1'b0,
                pause: PAUSE_IDLE, rxCount: 3'h0, rxShift: 7'h00, rxData: 8'h00,
                rxStrobe: 1'b0, txCount: 3'h0, txShift: 8'h00, txLoad: 1'b0,
                outBit: 1'b0, outEn: 1'b0, startPulse: 1'b0, endPulse: 1'b0,
                power: PWR_STANDBY};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs
    assign serialOut = st_reg.outBit;
    assign serialOutEn = st_reg.outEn;
    assign rxByte = st_reg.rxData;
    assign rxValid = st_reg.rxStrobe;
    assign txTake = st_reg.txLoad;
    assign frameStart = st_reg.startPulse;
    assign frameEnd = st_reg.endPulse;
    assign standby = (st_reg.power == PWR_STANDBY);
    assign active = (st_reg.power != PWR_STANDBY);
    assign paused = isPaused(st_reg.pause);

    // Protect zone holder, frozen while protect pin is low
    zone_freeze zoneHold
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .protectActive(!protSync_n),
        .zoneWrite(zoneWrite),
        .zoneIn(zoneIn),
        .zoneBits(zoneBits),
        .zoneRefused(zoneRefused)
    );

    // Assertions
    sequence selHigh;
        selSync_n;
    endsequence

    a_desel_floats: assert property (@(posedge mclk) disable iff (sys_rst)
        selHigh |=> !serialOutEn)
        else $error("output driven while deselected");
    a_pause_floats: assert property (@(posedge mclk) disable iff (sys_rst)
        paused |-> !serialOutEn)
        else $error("output driven during pause");
    a_pause_no_sample: assert property (@(posedge mclk) disable iff (sys_rst)
        paused |=> !rxValid)
        else $error("input sampled during pause");
    a_pause_entry: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(paused) |-> !$past(clkSync))
        else $error("pause began with clock high");
    a_no_decode_early: assert property (@(posedge mclk) disable iff (sys_rst)
        !st_reg.armed |-> !rxValid)
        else $error("byte decoded before first select");
    a_power_active: assert property (@(posedge mclk) disable iff (sys_rst)
        !selSync_n |=> active && !standby)
        else $error("selected but not active");
    a_standby_busy: assert property (@(posedge mclk) disable iff (sys_rst)
        (selSync_n && internalBusy) |=> !standby)
        else $error("standby during internal cycle");
    a_pause_reset: assert property (@(posedge mclk) disable iff (sys_rst)
        (paused && selRise) |=> !paused && !st_reg.inFrame)
        else $error("deselect under pause did not reset");
    a_tx_on_fall: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_reg.txShift != $past(st_reg.txShift)) && !$past(selFall)
        |-> $past(clkFall))
        else $error("output shifted off falling edge");

endmodule

// *** pkg/flash_front_params.svh ***
`ifndef FLASH_FRONT_PARAMS_SVH
`define FLASH_FRONT_PARAMS_SVH

// Bits per serial byte
`define BYTE_BITS 4'h8
// Last bit index in a byte
`define BYTE_LAST 3'h7
// Most data bytes per page program
`define PAGE_BYTES 9'h100
// Array geometry
`define SECTOR_COUNT 6'h20
`define PAGES_PER_SECTOR 9'h100
`define PAGE_WIDTH 9'h100
// Address width of the array, 2 Mbyte
`define ADDR_BITS 21
// Width of the protect zone field
`define ZONE_BITS 3
// Reset value of the zone field
`define ZONE_RESET 3'h0

`endif

// *** pkg/flash_front_pkg.sv ***
package flash_front_pkg;

    // Pause state machine, Gray coded along the usual path
    typedef enum logic [1:0]
    {
        PAUSE_IDLE = 2'h0,
        PAUSE_ARMED = 2'h1,
        PAUSE_ON = 2'h3,
        PAUSE_LEAVING = 2'h2
    } pause_e;

    // Power state of the device
    typedef enum logic [1:0]
    {
        PWR_STANDBY = 2'h0,
        PWR_ACTIVE = 2'h1,
        PWR_BUSY_DESEL = 2'h3
    } power_e;

endpackage

// *** core/sync_two_flop.sv ***
`timescale 1ns/1ps

// Two flip-flop synchroniser for one level
module sync_two_flop
#(
    // Level the pin rests at; reset loads it so no false edge follows reset
    parameter logic RESET_LEVEL = 1'b0
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic asyncIn,
    output logic syncOut
);

    // First stage, read only by the second stage
    logic stageOne_reg;

    // Both stages load the reset level of the pin
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stageOne_reg <= RESET_LEVEL;
            syncOut <= RESET_LEVEL;
        end
        else
        begin
            stageOne_reg <= asyncIn;
            syncOut <= stageOne_reg;
        end
    end

endmodule

// *** core/zone_freeze.sv ***
`timescale 1ns/1ps
`include "flash_front_params.svh"

// Holds the protect zone; a write is refused while protection is frozen
module zone_freeze
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic protectActive,
    input wire logic zoneWrite,
    input wire logic [`ZONE_BITS-1:0] zoneIn,
    output logic [`ZONE_BITS-1:0] zoneBits,
    output logic zoneRefused
);

    // Zone register and refusal flag
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            zoneBits <= `ZONE_RESET;
            zoneRefused <= 1'b0;
        end
        else
        begin
            zoneRefused <= zoneWrite && protectActive;
            if (zoneWrite && !protectActive)
            begin
                zoneBits <= zoneIn;
            end
        end
    end

    // A frozen zone never changes
    a_zone_frozen: assert property (@(posedge mclk) disable iff (sys_rst)
        protectActive |=> (zoneBits == $past(zoneBits)))
        else $error("zone changed while frozen");

endmodule

// *** testbench/spi_host.sv ***
`timescale 1ns/1ps

// Bus master on the serial link, paced by the system clock
module spi_host
(
    input wire logic mclk,
    input wire logic serialOut,
    input wire logic serialOutEn,
    output logic serialClk,
    output logic serialIn,
    output logic chipEnable_n,
    output logic pausePin_n
);
    // Idle clock level of the chosen mode
    logic idleLevel;
    // Seed of the filler pattern
    integer seed;

    // Pins start at defined levels, our one target deselected
    initial
    begin
        idleLevel = 1'b0;
        seed = 32'h0000_4f9e;
        serialClk = 1'b0;
        serialIn = 1'b0;
        chipEnable_n = 1'b1;
        pausePin_n = 1'b1;
    end

    // Data line changes every cycle while the target must ignore it
    always @(posedge mclk)
    begin
        if (chipEnable_n || !pausePin_n)
            serialIn <= 1'($random(seed));
    end

    // Waits system clock edges
    task automatic ticks(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Picks the mode while deselected; clock rests at its idle level
    task automatic setMode(input logic mode3);
        idleLevel = mode3;
        serialClk <= mode3;
        ticks(4);
    endtask

    // Select fall with the pause pin high opens a frame before any byte
    task automatic select();
        chipEnable_n <= 1'b0;
        ticks(6);
    endtask

    // Select rise closes the frame
    task automatic deselect();
        chipEnable_n <= 1'b1;
        ticks(8);
    endtask

    // Pause pin goes low only while selected; clock may be high or low
    task automatic hold(input logic on);
        pausePin_n <= !on;
        ticks(8);
    endtask

    // Clock toggles with no transfer meant; even counts end at rest
    task automatic noise(input int n);
        repeat (n)
        begin
            serialClk <= !serialClk;
            ticks(4);
        end
    endtask

    // One byte each way, most significant bit first
    task automatic xfer(input logic [7:0] txd, output logic [7:0] rxd);
        for (int i = 7; i >= 0; i--)
        begin
            serialClk <= 1'b0;
            serialIn <= txd[i];
            ticks(4);
            // Target samples on this rise
            serialClk <= 1'b1;
            ticks(4);
            // Output moved after the last fall; floating line reads inverted
            rxd[i] = serialOutEn ? serialOut : !serialOut;
        end
        serialClk <= idleLevel;
        ticks(4);
    endtask
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`include "flash_front_params.svh"

// Self-checking bench: host model on the link, byte queues as reference
module tb;
    // Clock, reset and core-side inputs
    logic mclk = 1'b0;
    logic sysRst = 1'b1;
    logic [7:0] txByte = 8'h5a;
    logic internalBusy = 1'b0;
    logic protectPin_n = 1'b1;
    logic zoneWrite = 1'b0;
    logic [`ZONE_BITS-1:0] zoneIn = 3'h0;
    // Link pins
    logic serialClk, serialIn, chipEnable_n, pausePin_n;
    // Design outputs
    logic serialOut, serialOutEn, txTake, rxValid, frameStart, frameEnd;
    logic standby, active, paused, zoneRefused;
    logic [7:0] rxByte;
    logic [`ZONE_BITS-1:0] zoneBits;
    // Reference queues for each direction
    logic [7:0] expRx[$];
    logic [7:0] expTx[$];
    // Zone the model holds, refusals seen and expected
    logic [`ZONE_BITS-1:0] zoneModel = 3'h0;
    int refusals = 0;
    int refusalsExp = 0;
    // Frame start and end pulses seen
    int framesSeen = 0;
    int framesEnded = 0;
    integer seed = 32'h0000_4f9e;
    int failures = 0;
    int checksDone = 0;

    // System clock
    always #25 mclk = ~mclk;

    serial_flash_spi_frontend serial_flash_spi_frontend_i
    (
        .mclk(mclk), .sys_rst(sysRst), .serialClk(serialClk), .serialIn(serialIn),
        .chipEnable_n(chipEnable_n), .pausePin_n(pausePin_n),
        .protectPin_n(protectPin_n), .serialOut(serialOut), .serialOutEn(serialOutEn),
        .txByte(txByte), .txTake(txTake), .rxByte(rxByte), .rxValid(rxValid),
        .frameStart(frameStart), .frameEnd(frameEnd), .internalBusy(internalBusy),
        .standby(standby), .active(active), .paused(paused), .zoneWrite(zoneWrite),
        .zoneIn(zoneIn), .zoneBits(zoneBits), .zoneRefused(zoneRefused)
    );

    spi_host spi_host_i
    (
        .mclk(mclk), .serialOut(serialOut), .serialOutEn(serialOutEn),
        .serialClk(serialClk), .serialIn(serialIn), .chipEnable_n(chipEnable_n),
        .pausePin_n(pausePin_n)
    );

    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Compares a byte-wide result
    task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Compares a flag
    task automatic chkFlag(input logic got, input logic exp);
        chkByte({7'h00, got}, {7'h00, exp});
    endtask

    // Waits clock edges
    task automatic ticks(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // One byte through the host; the returned byte is what the core queued
    task automatic sendByte(input logic [7:0] d);
        logic [7:0] got;
        expRx.push_back(d);
        spi_host_i.xfer(d, got);
        chkByte(got, expTx.pop_front());
    endtask

    // Zone write with the protect pin given; a frozen zone keeps its value
    task automatic zoneTry(input logic [2:0] val, input logic freeOk);
        protectPin_n <= freeOk;
        zoneIn <= val;
        ticks(4);
        zoneWrite <= 1'b1;
        ticks(1);
        zoneWrite <= 1'b0;
        ticks(3);
        if (freeOk)
            zoneModel = val;
        else
            refusalsExp++;
        chkByte(8'(zoneBits), 8'(zoneModel));
    endtask

    // Reference model: checks received bytes, follows transmit loads
    always @(posedge mclk)
    begin
        if (frameStart === 1'b1)
        begin
            expTx.delete();
            framesSeen++;
        end
        if (frameEnd === 1'b1)
            framesEnded++;
        if (txTake === 1'b1)
        begin
            expTx.push_back(txByte);
            txByte <= 8'($random(seed));
        end
        if (zoneRefused === 1'b1)
            refusals++;
        if (rxValid === 1'b1)
            chkByte(rxByte, expRx.size() ? expRx.pop_front() : 8'hxx);
    end

    // Cuts a hang short
    initial
    begin
        #1_000_000;
        failures++;
        report_and_stop();
    end

    // Main sequence
    initial
    begin
        ticks(8);
        sysRst <= 1'b0;
        ticks(3);
        chkFlag(standby, 1'b1);
        chkFlag(serialOutEn, 1'b0);
        chkFlag(paused, 1'b0);
        chkByte(8'(zoneBits), 8'h00);
        // Clocks before any select fall carry nothing
        spi_host_i.noise(16);
        for (int m = 0; m < 2; m++)
        begin
            spi_host_i.setMode(m[0]);
            spi_host_i.select();
            chkFlag(active, 1'b1);
            chkFlag(serialOutEn, 1'b1);
            repeat (3) sendByte(8'($random(seed)));
            spi_host_i.deselect();
            chkFlag(serialOutEn, 1'b0);
            chkFlag(standby, 1'b1);
        end
        // Busy core keeps the device active after deselect
        spi_host_i.setMode(1'b0);
        internalBusy <= 1'b1;
        spi_host_i.select();
        spi_host_i.deselect();
        chkFlag(standby, 1'b0);
        internalBusy <= 1'b0;
        ticks(4);
        chkFlag(standby, 1'b1);
        // Pause between bytes; clocks during it are ignored
        spi_host_i.select();
        sendByte(8'h81);
        spi_host_i.hold(1'b1);
        chkFlag(paused, 1'b1);
        chkFlag(serialOutEn, 1'b0);
        spi_host_i.noise(8);
        spi_host_i.hold(1'b0);
        chkFlag(paused, 1'b0);
        sendByte(8'h7e);
        // Deselect while paused; a reselect with the pin still low opens no frame, and a select after deselect and pin release opens one
        spi_host_i.hold(1'b1);
        spi_host_i.deselect();
        spi_host_i.select();
        spi_host_i.noise(16);
        chkFlag(serialOutEn, 1'b0);
        spi_host_i.deselect();
        spi_host_i.hold(1'b0);
        spi_host_i.select();
        sendByte(8'hc3);
        spi_host_i.deselect();
        // Pause pin moved with the clock high: entry and exit wait for clock low
        spi_host_i.setMode(1'b1);
        spi_host_i.select();
        spi_host_i.hold(1'b1);
        chkFlag(paused, 1'b0);
        chkFlag(serialOutEn, 1'b1);
        spi_host_i.noise(1);
        chkFlag(paused, 1'b1);
        spi_host_i.noise(1);
        spi_host_i.hold(1'b0);
        chkFlag(paused, 1'b1);
        chkFlag(serialOutEn, 1'b0);
        spi_host_i.noise(1);
        chkFlag(paused, 1'b0);
        sendByte(8'h3c);
        spi_host_i.deselect();
        // Every zone value, protect pin alternating
        for (int v = 0; v < 8; v++)
            zoneTry(v[2:0], v[0]);
        chkByte(8'(refusals), 8'(refusalsExp));
        chkByte(8'(framesSeen), 8'h06);
        chkByte(8'(framesEnded), 8'h06);
        report_and_stop();
    end
endmodule
